/* File: src/dmc_top.sv */
// APB slave with control and code registers and registered analog controls of the DAC
// Operation
// [RULE1] Eight-bit code spans low to high reference
// [RULE2] Bit 7 selects full or reduced range
// [RULE3] Bit 6 high selects high drive
// [RULE4] Bits 2:0 encode the six modes
// [RULE5] Reserved mode writes keep previous mode
// [RULE6] Stop disables amplifier, opens S1, S2
// [RULE7] Stop leaves register contents unchanged
// [RULE8] Control register accessible at any time
// [RULE9] Unbuffered pin connected only in unbuffered modes
// [RULE10] Amplifier output routed only when enabled
// [RULE11] Software waits settling after enable, stop
// [RULE12] Switch decode per mode table
// [RULE13] Reset gives off mode, all open
// [RULE14] Full range is reset default
// [RULE15] Separate code register sets network code
// [RULE16] Analog controls registered on bus clock
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
module dmc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpu_stop,
  output logic net_enable,
  output logic amp_enable,
  output logic full_range_sel,
  output logic high_drive_sel,
  output logic [7:0] net_code,
  output logic amp_feedback_switch,
  output logic buffer_path_switch,
  output logic unbuffered_path_switch
);

  ////////////////////////////////////////////////////////////////////////////
  // Stop input synchroniser

  logic stop_meta_reg; // First stage, read only by second
  logic stop_sync_reg; // Synchronised stop level

  // Two flip-flop synchroniser for stop pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_meta_reg <= 1'b0;
      stop_sync_reg <= 1'b0;
    end else begin
      stop_meta_reg <= cpu_stop;
      stop_sync_reg <= stop_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  logic [7:0] control_reg; // Range, drive and mode
  logic [7:0] code_reg; // Output code
  logic [7:0] control_next;
  logic [7:0] code_next;

  // Access phase strobes
  wire access = psel & penable;
  wire wr_en = access & pwrite & pstrb[0];
  wire sel_control = (paddr == dmc_pkg::DMC_CONTROL_OFS);
  wire sel_code = (paddr == dmc_pkg::DMC_CODE_OFS);
  wire sel_status = (paddr == dmc_pkg::DMC_STATUS_OFS);
  wire mapped = sel_control | sel_code | sel_status;

  // [RULE8] no access restriction, zero wait
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  // [RULE4] legal mode detection
  wire [2:0] wr_mode = pwdata[dmc_pkg::DMC_MODE_MSB:0];
  wire mode_legal = (wr_mode == dmc_pkg::DMC_MODE_OFF) | (wr_mode == dmc_pkg::DMC_MODE_AMP) |
                    (wr_mode == dmc_pkg::DMC_MODE_INT) | (wr_mode == dmc_pkg::DMC_MODE_UNBUF) |
                    (wr_mode == dmc_pkg::DMC_MODE_UNBUF_AMP) | (wr_mode == dmc_pkg::DMC_MODE_BUF);
  // [RULE5] reserved code keeps old mode
  wire [2:0] kept_mode = mode_legal ? wr_mode : control_reg[dmc_pkg::DMC_MODE_MSB:0];
  // [RULE2] range and [RULE3] drive bits
  wire [7:0] control_wr = {pwdata[dmc_pkg::DMC_FULL_RANGE_BIT], pwdata[dmc_pkg::DMC_DRIVE_BIT],
                           3'h0, kept_mode};

  assign control_next = (wr_en & sel_control) ? control_wr : control_reg;
  // [RULE15] code register write
  assign code_next = (wr_en & sel_code) ? pwdata[7:0] : code_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Register storage; stop does not touch it
  // [RULE7] stop keeps registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // [RULE13] [RULE14] reset defaults
      control_reg <= dmc_pkg::DMC_CONTROL_RST;
      code_reg <= dmc_pkg::DMC_CODE_RST;
    end else begin
      control_reg <= control_next;
      code_reg <= code_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode and output registers

  logic dec_net;
  logic dec_amp;
  logic dec_s1;
  logic dec_s2;
  logic dec_s3;

  // Mode decoder with stop override
  dmc_decode u_decode (
    .mode(control_reg[dmc_pkg::DMC_MODE_MSB:0]),
    .stop_mode(stop_sync_reg),
    .net_en(dec_net),
    .amp_en(dec_amp),
    .s1_close(dec_s1),
    .s2_close(dec_s2),
    .s3_close(dec_s3)
  );

  // Registered analog controls
  // [RULE16] registered controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      net_enable <= 1'b0;
      amp_enable <= 1'b0;
      full_range_sel <= dmc_pkg::DMC_CONTROL_RST[dmc_pkg::DMC_FULL_RANGE_BIT];
      high_drive_sel <= dmc_pkg::DMC_CONTROL_RST[dmc_pkg::DMC_DRIVE_BIT];
      net_code <= dmc_pkg::DMC_CODE_RST;
      amp_feedback_switch <= 1'b0;
      buffer_path_switch <= 1'b0;
      unbuffered_path_switch <= 1'b0;
    end else begin
      net_enable <= dec_net;
      // [RULE10] amplifier output gating
      amp_enable <= dec_amp;
      full_range_sel <= control_reg[dmc_pkg::DMC_FULL_RANGE_BIT];
      high_drive_sel <= control_reg[dmc_pkg::DMC_DRIVE_BIT];
      // [RULE1] full 8-bit code
      net_code <= code_reg;
      amp_feedback_switch <= dec_s1;
      buffer_path_switch <= dec_s2;
      unbuffered_path_switch <= dec_s3;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  // Status shows registered enables and switches (not range, drive or code) and synchronised stop
  wire [31:0] status_word = {24'h0, stop_sync_reg, 2'h0, unbuffered_path_switch, buffer_path_switch,
                             amp_feedback_switch, amp_enable, net_enable};
  wire [31:0] rd_mux = sel_control ? {24'h0, control_reg} :
                       sel_code ? {24'h0, code_reg} :
                       sel_status ? status_word : 32'h0;

  // Read data register, loaded in setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  // Control write carrying a reserved mode code
  sequence s_reserved_write;
    wr_en && sel_control && !mode_legal;
  endsequence

  // Control write carrying one of the six mode codes
  sequence s_legal_write;
    wr_en && sel_control && mode_legal;
  endsequence

  // Accepted write to the code register
  sequence s_code_write;
    wr_en && sel_code;
  endsequence

  // Control read: setup cycle, then its access cycle
  sequence s_control_read;
    (psel && !penable && !pwrite && sel_control) ##1 (psel && penable && !pwrite && sel_control);
  endsequence

  // Stop pin high long enough to cross the synchroniser
  sequence s_stop_held;
    cpu_stop [*3];
  endsequence

  // Stop pin low long enough to cross the synchroniser
  sequence s_run_held;
    !cpu_stop [*3];
  endsequence

  property p_reserved_keep;
    @(posedge pclk) disable iff (!presetn)
    s_reserved_write |=> (control_reg[2:0] == $past(control_reg[2:0]));
  endproperty
  a_reserved_keep: assert property (p_reserved_keep) else $error("reserved mode changed mode"); // [RULE5]

  property p_stop_amp;
    @(posedge pclk) disable iff (!presetn)
    stop_sync_reg |=> (!amp_enable && !amp_feedback_switch && !buffer_path_switch);
  endproperty
  a_stop_amp: assert property (p_stop_amp) else $error("amplifier active in stop"); // [RULE6]

  property p_stop_keep;
    @(posedge pclk) disable iff (!presetn)
    (stop_sync_reg && !(wr_en && sel_control)) |=> $stable(control_reg);
  endproperty
  a_stop_keep: assert property (p_stop_keep) else $error("control changed in stop"); // [RULE7]

  property p_s2_buf;
    @(posedge pclk) disable iff (!presetn)
    buffer_path_switch |-> ($past(control_reg[2:0]) == dmc_pkg::DMC_MODE_BUF);
  endproperty
  a_s2_buf: assert property (p_s2_buf) else $error("S2 closed outside buffered mode"); // [RULE12]

  property p_s3_mode;
    @(posedge pclk) disable iff (!presetn)
    ##1 (unbuffered_path_switch == ($past(control_reg[2:1]) == 2'h2));
  endproperty
  a_s3_mode: assert property (p_s3_mode) else $error("unbuffered switch mismatch"); // [RULE9]

  property p_amp_route;
    @(posedge pclk) disable iff (!presetn)
    (control_reg[2:0] == dmc_pkg::DMC_MODE_BUF && !stop_sync_reg) |=> amp_enable && net_enable;
  endproperty
  a_amp_route: assert property (p_amp_route) else $error("buffered mode not enabled"); // [RULE10]

  property p_code_write;
    @(posedge pclk) disable iff (!presetn)
    s_code_write |=> ##1 (net_code == $past(pwdata[7:0], 2));
  endproperty
  a_code_write: assert property (p_code_write) else $error("code not applied"); // [RULE15]

  property p_off_quiet;
    @(posedge pclk) disable iff (!presetn)
    (control_reg[2:0] == dmc_pkg::DMC_MODE_OFF) |=> (!net_enable && !amp_enable && !unbuffered_path_switch);
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("off mode not quiet"); // [RULE13]

  property p_range_out;
    @(posedge pclk) disable iff (!presetn)
    ##1 (full_range_sel == $past(control_reg[7]));
  endproperty
  a_range_out: assert property (p_range_out) else $error("range output mismatch"); // [RULE2]

  // A legal mode code lands in the mode field
  property p_legal_mode;
    @(posedge pclk) disable iff (!presetn)
    s_legal_write |=> (control_reg[dmc_pkg::DMC_MODE_MSB:0] == $past(pwdata[dmc_pkg::DMC_MODE_MSB:0]));
  endproperty
  a_legal_mode: assert property (p_legal_mode) else $error("legal mode write lost"); // [RULE4]

  // Drive select output follows the control bit
  property p_drive_out;
    @(posedge pclk) disable iff (!presetn)
    ##1 (high_drive_sel == $past(control_reg[dmc_pkg::DMC_DRIVE_BIT]));
  endproperty
  a_drive_out: assert property (p_drive_out) else $error("drive output mismatch"); // [RULE3]

  // Control read returns the register as it stood at setup
  property p_read_control;
    @(posedge pclk) disable iff (!presetn)
    s_control_read |-> (prdata == {24'h0, $past(control_reg)});
  endproperty
  a_read_control: assert property (p_read_control) else $error("control read data wrong"); // [RULE8]

  // Stop held past the synchroniser silences the amplifier path
  property p_stop_enter;
    @(posedge pclk) disable iff (!presetn)
    s_stop_held |=> (!amp_enable && !amp_feedback_switch && !buffer_path_switch);
  endproperty
  a_stop_enter: assert property (p_stop_enter) else $error("stop pin ignored"); // [RULE6]

  // Out of stop, S1 follows the mode table again
  property p_run_s1;
    @(posedge pclk) disable iff (!presetn)
    s_run_held |=> (amp_feedback_switch == (($past(control_reg[2:0]) == dmc_pkg::DMC_MODE_AMP) ||
                                            ($past(control_reg[2:0]) == dmc_pkg::DMC_MODE_UNBUF_AMP)));
  endproperty
  a_run_s1: assert property (p_run_s1) else $error("S1 mismatch out of stop"); // [RULE12]

  // Amplifier only runs in its three modes and never in stop
  property p_amp_modes;
    @(posedge pclk) disable iff (!presetn)
    amp_enable |-> (!$past(stop_sync_reg) && (($past(control_reg[2:0]) == dmc_pkg::DMC_MODE_AMP) ||
                    ($past(control_reg[2:0]) == dmc_pkg::DMC_MODE_UNBUF_AMP) ||
                    ($past(control_reg[2:0]) == dmc_pkg::DMC_MODE_BUF)));
  endproperty
  a_amp_modes: assert property (p_amp_modes) else $error("amplifier on outside its modes"); // [RULE10]

endmodule : dmc_top

/* File: src/dmc_pkg.sv */
// Package with register map, field layout, reset values and mode codes of the DAC mode control
package dmc_pkg;

  // Register byte offsets (word aligned)
  localparam logic [11:0] DMC_CONTROL_OFS = 12'h000;
  localparam logic [11:0] DMC_CODE_OFS = 12'h004;
  localparam logic [11:0] DMC_STATUS_OFS = 12'h008;

  // Control register field positions
  localparam int DMC_FULL_RANGE_BIT = 7;
  localparam int DMC_DRIVE_BIT = 6;
  localparam int DMC_MODE_MSB = 2;

  // Reset values
  localparam logic [7:0] DMC_CONTROL_RST = 8'h80;
  localparam logic [7:0] DMC_CODE_RST = 8'h00;

  // Mode codes
  localparam logic [2:0] DMC_MODE_OFF = 3'h0;
  localparam logic [2:0] DMC_MODE_AMP = 3'h1;
  localparam logic [2:0] DMC_MODE_INT = 3'h2;
  localparam logic [2:0] DMC_MODE_UNBUF = 3'h4;
  localparam logic [2:0] DMC_MODE_UNBUF_AMP = 3'h5;
  localparam logic [2:0] DMC_MODE_BUF = 3'h7;

endpackage : dmc_pkg

/* File: src/dmc_decode.sv */
// Combinational mode decoder from mode code and stop request to analog controls
`timescale 1ns/10ps
module dmc_decode (
  input wire logic [2:0] mode,
  input wire logic stop_mode,
  output logic net_en,
  output logic amp_en,
  output logic s1_close,
  output logic s2_close,
  output logic s3_close
);

  // Per-mode decode before stop override
  wire is_amp = (mode == dmc_pkg::DMC_MODE_AMP);
  wire is_int = (mode == dmc_pkg::DMC_MODE_INT);
  wire is_unbuf = (mode == dmc_pkg::DMC_MODE_UNBUF);
  wire is_unbuf_amp = (mode == dmc_pkg::DMC_MODE_UNBUF_AMP);
  wire is_buf = (mode == dmc_pkg::DMC_MODE_BUF);

  // [RULE12] switch decode
  assign net_en = is_int | is_unbuf | is_unbuf_amp | is_buf;
  // [RULE6] stop forces amplifier off
  assign amp_en = (is_amp | is_unbuf_amp | is_buf) & ~stop_mode;
  // [RULE6] stop opens S1 and S2
  assign s1_close = (is_amp | is_unbuf_amp) & ~stop_mode;
  assign s2_close = is_buf & ~stop_mode;
  // [RULE9] unbuffered path only in unbuffered modes
  assign s3_close = is_unbuf | is_unbuf_amp;

endmodule : dmc_decode

/* File: tb/dmc_analog_model.sv */
// Behavioural model of the analog network, amplifier and pin switches
`timescale 1ns/10ps
module dmc_analog_model #(
  parameter int SETTLE_CYCLES = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic net_enable,
  input wire logic amp_enable,
  input wire logic unbuffered_path_switch,
  output logic unbuf_pin_live,
  output logic amp_pin_live,
  output logic settled
);
  // Cycles since the analog section was powered
  logic [7:0] settle_cnt;
  // Amplifier enable one cycle ago, restarts settling on stop exit
  logic amp_seen_reg;
  assign unbuf_pin_live = net_enable & unbuffered_path_switch;
  assign amp_pin_live = amp_enable;
  // Settling after enable or stop exit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_cnt <= 8'h00;
      amp_seen_reg <= 1'b0;
    end else begin
      amp_seen_reg <= amp_enable;
      if (!amp_enable && !net_enable) begin
        settle_cnt <= 8'h00;
      end else if (amp_enable && !amp_seen_reg) begin
        settle_cnt <= 8'h00;
      end else if (settle_cnt < 8'(SETTLE_CYCLES)) begin
        settle_cnt <= settle_cnt + 8'h01;
      end
    end
  end
  assign settled = (settle_cnt == 8'(SETTLE_CYCLES));
endmodule : dmc_analog_model

/* File: tb/dmc_top_tb.sv */
// Self-checking testbench of the DAC mode control
`timescale 1ns/10ps
module dmc_top_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cpu_stop = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, err, net_enable, amp_enable, full_range_sel, high_drive_sel;
  logic amp_feedback_switch, buffer_path_switch, unbuffered_path_switch, unbuf_live, amp_live, settled;
  logic [7:0] net_code;
  logic [4:0] ctl;
  int miscompares = 0, tests_run = 0;
  // Analog controls gathered as net, amp, S1, S2, S3
  assign ctl = {net_enable, amp_enable, amp_feedback_switch, buffer_path_switch, unbuffered_path_switch};
  always #10 pclk = ~pclk;
  dmc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_stop(cpu_stop), .net_enable(net_enable), .amp_enable(amp_enable), .full_range_sel(full_range_sel),
    .high_drive_sel(high_drive_sel), .net_code(net_code), .amp_feedback_switch(amp_feedback_switch),
    .buffer_path_switch(buffer_path_switch), .unbuffered_path_switch(unbuffered_path_switch));
  dmc_analog_model i_ana (.pclk(pclk), .presetn(presetn), .net_enable(net_enable), .amp_enable(amp_enable),
    .unbuffered_path_switch(unbuffered_path_switch), .unbuf_pin_live(unbuf_live), .amp_pin_live(amp_live),
    .settled(settled));
  // Counts and reports one comparison
  task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check
  // Prints the verdict and ends the run
  task results();
    $display("Counts: %0d compared, %0d mismatched", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results
  // One APB transfer, held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 50) begin
      miscompares++;
      results();
    end
  endtask : apb
  // Lets the registered controls settle
  task settle();
    repeat (4) @(posedge pclk);
    #1;
  endtask : settle
  // Reset values of registers and controls
  task t_reset();
    apb(1'b0, 12'h000, 32'h0); check(rd, 32'h80, "control reset");
    apb(1'b0, 12'h004, 32'h0); check(rd, 32'h00, "code reset");
    check({ctl, full_range_sel}, 6'h01, "reset controls");
  endtask : t_reset
  // Every mode code against the switch table
  task t_modes();
    static logic [2:0] m [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h7};
    static logic [4:0] e [6] = '{5'h00, 5'h0c, 5'h10, 5'h11, 5'h1d, 5'h1a};
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 12'h000, {24'h0, 1'b1, i[0], 3'h0, m[i]});
      settle();
      check(ctl, e[i], "mode controls");
      check({unbuf_live, amp_live, high_drive_sel}, {e[i][0], e[i][3], i[0]}, "pins");
      apb(1'b0, 12'h000, 32'h0); check(rd, {24'h0, 1'b1, i[0], 3'h0, m[i]}, "control readback");
    end
  endtask : t_modes
  // Reserved codes keep the mode, upper bits still taken
  task t_reserved();
    apb(1'b1, 12'h000, 32'h43);
    apb(1'b0, 12'h000, 32'h0); check(rd, 32'h47, "reserved 3");
    apb(1'b1, 12'h000, 32'h86);
    apb(1'b0, 12'h000, 32'h0); check(rd, 32'h87, "reserved 6");
    settle(); check({full_range_sel, high_drive_sel}, 2'h2, "range and drive");
  endtask : t_reserved
  // Waits a bounded time for the analog section to settle
  task wait_settled();
    int n;
    n = 0;
    while (settled !== 1'b1 && n < 20) begin
      @(posedge pclk);
      #1;
      n++;
    end
    check(settled, 1'b1, "settled after stop");
    if (settled !== 1'b1) begin
      results();
    end
  endtask : wait_settled
  // Stop in unbuffered amp mode opens S1 and disables amp, registers kept
  task t_stop();
    apb(1'b1, 12'h000, 32'h45);
    @(posedge pclk); cpu_stop <= 1'b1;
    settle(); check(ctl, 5'h11, "stop controls");
    apb(1'b0, 12'h000, 32'h0); check(rd, 32'h45, "read in stop");
    apb(1'b0, 12'h008, 32'h0); check(rd, 32'h91, "status in stop");
    @(posedge pclk); cpu_stop <= 1'b0;
    settle(); check(ctl, 5'h1d, "after stop");
    check(settled, 1'b0, "settling after stop");
    wait_settled();
  endtask : t_stop
  // Code register and an unmapped address
  task t_code();
    apb(1'b1, 12'h004, 32'ha5);
    settle(); check(net_code, 8'ha5, "network code");
    apb(1'b1, 12'h0fc, 32'h12); check(err, 1'b1, "unmapped error");
    apb(1'b0, 12'h004, 32'h0); check(rd, 32'ha5, "code kept");
  endtask : t_code
  // Main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_modes();
    t_reserved();
    t_stop();
    t_code();
    results();
  end
endmodule : dmc_top_tb
